// file: logic/ctc_pkg.sv
// Purpose: Shared constants and state types for the conversion timing control
// Assumes: 32-bit register port, byte offsets, one 100 MHz clock
// Notes:   Divider values are shadowed and applied at the next conversion strobe
package ctc_pkg;
   // ****************************************
   // Widths and clock figures
   // ****************************************
   localparam int CTC_DIV_W        = 8;          // Divider register width
   localparam int CTC_SMP_W        = 14;         // Converter sample width
   localparam int CTC_ADDR_W       = 8;          // Register port address width
   localparam int CTC_FIFO_DEPTH   = 16;         // Transmit sample buffer depth
   localparam int CTC_CLK_HZ       = 100000000;  // System clock rate
   localparam int CTC_SCF_HZ       = 288000;     // Target filter clock rate
   // Filter clock toggles once per divider wrap, so two wraps per period
   localparam int CTC_DIVA_DEF     = CTC_CLK_HZ / (2 * CTC_SCF_HZ);
   localparam int CTC_DIVB_DEF     = 36;         // 288 kHz / 36 = 8 kHz rate

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] CTC_OFS_CTRL   = 8'h00;  // Mode, gain, input, bypass
   localparam logic [7:0] CTC_OFS_RXA    = 8'h04;  // Receive filter divider
   localparam logic [7:0] CTC_OFS_RXB    = 8'h08;  // Receive conversion divider
   localparam logic [7:0] CTC_OFS_TXA    = 8'h0C;  // Transmit filter divider
   localparam logic [7:0] CTC_OFS_TXB    = 8'h10;  // Transmit conversion divider
   localparam logic [7:0] CTC_OFS_TXDATA = 8'h14;  // Push one D/A sample
   localparam logic [7:0] CTC_OFS_STATUS = 8'h18;  // Buffer state, underrun

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTC_CTRL_SYNC   = 0;   // Locked transmit/receive timing
   localparam int CTC_CTRL_BYTE   = 1;   // Two 8-bit bytes per transfer
   localparam int CTC_CTRL_GAIN   = 2;   // Two bits: 00 x1, 01 x2, 10 x4
   localparam int CTC_CTRL_AUX    = 4;   // Auxiliary input pair
   localparam int CTC_CTRL_BYPASS = 5;   // Skip band-pass filter
   localparam int CTC_ST_EMPTY    = 0;   // Buffer empty
   localparam int CTC_ST_FULL     = 1;   // Buffer full
   localparam int CTC_ST_UNDER    = 2;   // Sticky underrun, write 1 clears
   localparam int CTC_ST_LEVEL    = 8;   // Buffer level field

   // ****************************************
   // Reset values and gain codes
   // ****************************************
   localparam logic [5:0] CTC_CTRL_RST = 6'h00;  // Async, word mode, x1, main
   localparam logic [1:0] CTC_GAIN_X1  = 2'h0;   // Unity gain
   localparam logic [1:0] CTC_GAIN_X4  = 2'h2;   // Highest legal code
   localparam logic [CTC_DIV_W-1:0] CTC_DIVA_RST = CTC_DIV_W'(CTC_DIVA_DEF);
   localparam logic [CTC_DIV_W-1:0] CTC_DIVB_RST = CTC_DIV_W'(CTC_DIVB_DEF);

   // ****************************************
   // Top-level state
   // ****************************************
   typedef struct packed {
      logic [5:0]           ctrl_sh;    // Control as written
      logic [5:0]           ctrl;       // Control in force
      logic [CTC_DIV_W-1:0] rxa_sh, rxb_sh, txa_sh, txb_sh;  // Shadows
      logic [CTC_DIV_W-1:0] rxa, rxb, txa, txb;              // In force
      logic [CTC_DIV_W-1:0] rx_cnt_a, rx_cnt_b;              // Receive counters
      logic [CTC_DIV_W-1:0] tx_cnt_a, tx_cnt_b;              // Transmit counters
      logic                 rx_fclk, tx_fclk;                // Filter clocks
      logic                 adc_stb, dac_stb;                // Strobes
      logic [CTC_SMP_W-1:0] dac_data;   // Sample at the converter
      logic                 underrun;   // Sticky empty-at-strobe
      logic [31:0]          rd_data;    // Read answer
   } ctc_state_t;
endpackage

// file: logic/ctc_conv_timing.sv
// Purpose: Filter clock and conversion rate generation with mode control
// Assumes: Register port master never reads and writes in one cycle
// Notes:   Buffer drains one sample per D/A strobe
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

// ****************************************
// Transmit sample buffer
// ****************************************
module ctc_fifo #(
   parameter int W = 14,   // Word width
   parameter int D = 16    // Depth, power of two
) (
   input  wire logic         sys_clk_in,    // System clock
   input  wire logic         rst_in,        // Sync reset, high
   input  wire logic         in_valid_in,   // Word offered
   output logic              in_ready_out,  // Room for a word
   input  wire logic [W-1:0] in_data_in,    // Word in
   output logic              out_valid_out, // Word waiting
   input  wire logic         out_ready_in,  // Consumer takes word
   output logic [W-1:0]      out_data_out,  // Oldest word
   output logic [$clog2(D):0] level_out     // Words held
);
   localparam int AW = $clog2(D);  // Pointer width

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;    // Storage
      logic [AW-1:0]       wp, rp; // Pointers
      logic [AW:0]         cnt;    // Level
      logic                full;   // No room
      logic                empty;  // Nothing held
   } ctc_fifo_t;

   ctc_fifo_t st, next_st;  // State and next state
   logic      push, pop;    // Accepted handshakes

   // Next state from both handshakes
   always_comb begin
      next_st = st;
      push    = in_valid_in && !st.full;
      pop     = out_ready_in && !st.empty;
      if (push) begin
         next_st.mem[st.wp] = in_data_in;
         next_st.wp         = st.wp + AW'(1);
      end
      if (pop) begin
         next_st.rp = st.rp + AW'(1);
      end
      next_st.cnt   = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
      next_st.full  = (next_st.cnt == (AW+1)'(D));
      next_st.empty = (next_st.cnt == '0);
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st       <= '0;
         st.empty <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign in_ready_out  = !st.full;
   assign out_valid_out = !st.empty;
   assign out_data_out  = st.mem[st.rp];
   assign level_out     = st.cnt;
endmodule // ctc_fifo

module ctc_conv_timing
   import ctc_pkg::*;
#(
   parameter int FIFO_W = ctc_pkg::CTC_SMP_W,      // Sample width
   parameter int FIFO_D = ctc_pkg::CTC_FIFO_DEPTH  // Sample buffer depth
) (
   input  wire logic                           sys_clk_in,      // Master clock
   input  wire logic                           rst_in,          // Sync reset, high
   input  wire logic [ctc_pkg::CTC_ADDR_W-1:0] addr_in,         // Register byte address
   input  wire logic [31:0]                    wr_data_in,      // Write data
   input  wire logic                           wr_in,           // Write strobe
   input  wire logic                           rd_in,           // Read strobe
   output logic      [31:0]                    rd_data_out,     // Read data, next cycle
   output logic                                rx_fclk_out,     // Band-pass filter clock
   output logic                                tx_fclk_out,     // Low-pass filter clock
   output logic                                adc_stb_out,     // A/D conversion pulse
   output logic                                dac_stb_out,     // D/A conversion pulse
   output logic      [ctc_pkg::CTC_SMP_W-1:0]  dac_data_out,    // Sample for D/A
   output logic                                sync_mode_out,   // Locked timing
   output logic                                byte_mode_out,   // Two-byte transfers
   output logic      [1:0]                     gain_out,        // Input gain code
   output logic                                aux_sel_out,     // Auxiliary inputs
   output logic                                bypass_out,      // Filter bypassed
   output logic                                tx_ready_out     // Buffer has room
);
   import ctc_pkg::*;

   ctc_state_t                st, next_st;   // State and next state
   logic                      tx_tick;       // Transmit divider A wrap
   logic                      rx_tick;       // Receive filter tick used
   logic                      tx_wrap_b;     // Transmit divider B wrap
   logic                      rx_wrap_b;     // Receive divider B wrap
   logic                      dac_now;       // D/A strobe this cycle
   logic                      adc_now;       // A/D strobe this cycle
   logic                      sync_now;      // Mode in force
   logic                      push;          // Sample write
   logic                      f_valid;       // Buffer holds a sample
   logic [FIFO_W-1:0]         f_data;        // Oldest sample
   logic [$clog2(FIFO_D):0]   f_level;       // Buffer level
   logic [1:0]                gain_wr;       // Gain as written

   // ****************************************
   // Sample buffer
   // ****************************************
   ctc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
      .sys_clk_in    (sys_clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (push),
      .in_ready_out  (tx_ready_out),
      .in_data_in    (wr_data_in[FIFO_W-1:0]),
      .out_valid_out (f_valid),
      .out_ready_in  (dac_now),
      .out_data_out  (f_data),
      .level_out     (f_level)
   );

   // Wrap test that treats a zero divider as one
   function automatic logic wrap(input logic [CTC_DIV_W-1:0] c, input logic [CTC_DIV_W-1:0] d);
      wrap = (d == '0) || (c >= d - CTC_DIV_W'(1));
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_st  = st;
      sync_now = st.ctrl[CTC_CTRL_SYNC];
      push     = wr_in && (addr_in == CTC_OFS_TXDATA);
      gain_wr  = wr_data_in[CTC_CTRL_GAIN +: 2];
      // Transmit divider A tick
      tx_tick  = wrap(st.tx_cnt_a, st.txa);
      // receive divider A, shared when locked
      rx_tick  = sync_now ? tx_tick : wrap(st.rx_cnt_a, st.rxa);
      tx_wrap_b = tx_tick && !st.tx_fclk && wrap(st.tx_cnt_b, st.txb);
      rx_wrap_b = rx_tick && !st.rx_fclk && wrap(st.rx_cnt_b, st.rxb);
      dac_now  = tx_wrap_b;
      adc_now  = sync_now ? tx_wrap_b : rx_wrap_b;

      // Divider A counters and filter clocks
      next_st.tx_cnt_a = tx_tick ? '0 : st.tx_cnt_a + CTC_DIV_W'(1);
      next_st.tx_fclk  = tx_tick ? !st.tx_fclk : st.tx_fclk;
      next_st.rx_cnt_a = wrap(st.rx_cnt_a, st.rxa) ? '0 : st.rx_cnt_a + CTC_DIV_W'(1);
      // locked mode copies low-pass clock, no phase slip
      if (sync_now) begin
         next_st.rx_fclk = next_st.tx_fclk;
      end else begin
         next_st.rx_fclk = rx_tick ? !st.rx_fclk : st.rx_fclk;
      end
      if (tx_tick && !st.tx_fclk) begin
         next_st.tx_cnt_b = tx_wrap_b ? '0 : st.tx_cnt_b + CTC_DIV_W'(1);
      end
      if (rx_tick && !st.rx_fclk) begin
         next_st.rx_cnt_b = rx_wrap_b ? '0 : st.rx_cnt_b + CTC_DIV_W'(1);
      end
      next_st.dac_stb = dac_now;
      next_st.adc_stb = adc_now;

      if (dac_now) begin
         next_st.txa  = st.txa_sh;
         next_st.txb  = st.txb_sh;
         next_st.ctrl = st.ctrl_sh;
         if (sync_now) begin
            next_st.rxa = st.rxa_sh;
            next_st.rxb = st.rxb_sh;
         end
      end
      if (adc_now && !sync_now) begin
         next_st.rxa = st.rxa_sh;
         next_st.rxb = st.rxb_sh;
      end

      // Sample pop and underrun, set wins over clear
      if (dac_now && f_valid) begin
         next_st.dac_data = f_data;
      end
      if (wr_in && addr_in == CTC_OFS_STATUS && wr_data_in[CTC_ST_UNDER]) begin
         next_st.underrun = 1'b0;
      end
      if (dac_now && !f_valid) begin
         next_st.underrun = 1'b1;
      end

      // Register writes
      if (wr_in) begin
         case (addr_in)
            CTC_OFS_CTRL: begin
               next_st.ctrl_sh = wr_data_in[5:0];
               // illegal gain code falls back to unity
               if (gain_wr > CTC_GAIN_X4) begin
                  next_st.ctrl_sh[CTC_CTRL_GAIN +: 2] = CTC_GAIN_X1;
               end
            end
            CTC_OFS_RXA: next_st.rxa_sh = wr_data_in[CTC_DIV_W-1:0];
            CTC_OFS_RXB: next_st.rxb_sh = wr_data_in[CTC_DIV_W-1:0];
            CTC_OFS_TXA: next_st.txa_sh = wr_data_in[CTC_DIV_W-1:0];
            CTC_OFS_TXB: next_st.txb_sh = wr_data_in[CTC_DIV_W-1:0];
            default: ;  // Sample pushes, status writes and unmapped writes
         endcase
      end

      // Register reads, unmapped reads as zero
      next_st.rd_data = '0;
      if (rd_in) begin
         case (addr_in)
            CTC_OFS_CTRL: next_st.rd_data = 32'(st.ctrl_sh);
            CTC_OFS_RXA:  next_st.rd_data = 32'(st.rxa_sh);
            CTC_OFS_RXB:  next_st.rd_data = 32'(st.rxb_sh);
            CTC_OFS_TXA:  next_st.rd_data = 32'(st.txa_sh);
            CTC_OFS_TXB:  next_st.rd_data = 32'(st.txb_sh);
            CTC_OFS_STATUS: begin
               next_st.rd_data[CTC_ST_EMPTY] = !f_valid;
               next_st.rd_data[CTC_ST_FULL]  = !tx_ready_out;
               next_st.rd_data[CTC_ST_UNDER] = st.underrun;
               next_st.rd_data[CTC_ST_LEVEL +: $clog2(FIFO_D)+1] = f_level;
            end
            default: next_st.rd_data = '0;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st        <= '0;
         st.ctrl   <= CTC_CTRL_RST;
         st.ctrl_sh <= CTC_CTRL_RST;
         st.rxa    <= CTC_DIVA_RST;
         st.txa    <= CTC_DIVA_RST;
         st.rxa_sh <= CTC_DIVA_RST;
         st.txa_sh <= CTC_DIVA_RST;
         st.rxb    <= CTC_DIVB_RST;
         st.txb    <= CTC_DIVB_RST;
         st.rxb_sh <= CTC_DIVB_RST;
         st.txb_sh <= CTC_DIVB_RST;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rd_data_out   = st.rd_data;
   assign rx_fclk_out   = st.rx_fclk;
   assign tx_fclk_out   = st.tx_fclk;
   assign adc_stb_out   = st.adc_stb;
   assign dac_stb_out   = st.dac_stb;
   assign dac_data_out  = st.dac_data;
   assign sync_mode_out = st.ctrl[CTC_CTRL_SYNC];
   assign byte_mode_out = st.ctrl[CTC_CTRL_BYTE];
   assign gain_out      = st.ctrl[CTC_CTRL_GAIN +: 2];
   assign aux_sel_out   = st.ctrl[CTC_CTRL_AUX];
   assign bypass_out    = st.ctrl[CTC_CTRL_BYPASS];
endmodule // ctc_conv_timing

// file: bench/ctc_conv_timing_props.sv
// Purpose: Port checks of the conversion timing control
// Assumes: One clock, sync reset high
// Notes:   Bound to every ctc_conv_timing instance
`timescale 1ns/1ps
module ctc_conv_timing_props (
   input wire logic        sys_clk_in,    // Clock
   input wire logic        rst_in,        // Reset
   input wire logic        rd_in,         // Read strobe
   input wire logic [31:0] rd_data_out,   // Read data
   input wire logic        rx_fclk_out,   // Rx filter clock
   input wire logic        tx_fclk_out,   // Tx filter clock
   input wire logic        adc_stb_out,   // A/D pulse
   input wire logic        dac_stb_out,   // D/A pulse
   input wire logic        sync_mode_out, // Locked timing
   input wire logic        byte_mode_out, // Byte transfers
   input wire logic [1:0]  gain_out,      // Gain code
   input wire logic        aux_sel_out,   // Aux inputs
   input wire logic        bypass_out     // Filter bypassed
);
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   wire [5:0] mode = {bypass_out, aux_sel_out, gain_out, byte_mode_out, sync_mode_out};
   a_rd_idle_zero: assert property (!$past(rd_in) |-> rd_data_out == 32'h0)
      else $error("read data outside answer cycle");
   a_sync_fclk_eq: assert property (sync_mode_out [*3] |-> rx_fclk_out == tx_fclk_out)
      else $error("filter clocks differ in locked mode");
   a_sync_stb_eq: assert property (sync_mode_out [*3] |-> adc_stb_out == dac_stb_out)
      else $error("conversion pulses differ in locked mode");
   a_dac_one_cycle: assert property (dac_stb_out |=> !dac_stb_out)
      else $error("D/A pulse longer than one cycle");
   a_dac_on_rise: assert property (dac_stb_out |-> $rose(tx_fclk_out))
      else $error("D/A pulse not locked to filter clock");
   a_adc_on_rise: assert property (adc_stb_out |-> $rose(rx_fclk_out))
      else $error("A/D pulse not locked to filter clock");
   a_gain_legal: assert property (gain_out != 2'h3)
      else $error("illegal gain code");
   a_mode_at_strobe: assert property ($changed(mode) |-> dac_stb_out)
      else $error("mode changed between conversions");
   c_sync: cover property (sync_mode_out && dac_stb_out);
   c_byte: cover property (byte_mode_out && gain_out == 2'h2);
   c_bypass: cover property (bypass_out && adc_stb_out);
endmodule // ctc_conv_timing_props

bind ctc_conv_timing ctc_conv_timing_props u_props (.sys_clk_in(sys_clk_in),
   .rst_in(rst_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
   .rx_fclk_out(rx_fclk_out), .tx_fclk_out(tx_fclk_out), .adc_stb_out(adc_stb_out),
   .dac_stb_out(dac_stb_out), .sync_mode_out(sync_mode_out),
   .byte_mode_out(byte_mode_out), .gain_out(gain_out), .aux_sel_out(aux_sel_out),
   .bypass_out(bypass_out));

// file: bench/ctc_dsp_model.sv
// Purpose: Processor side that times the conversion pulses
// Assumes: One clock, sync reset high
// Notes:   A period is cycles from one pulse to the next
`timescale 1ns/1ps
module ctc_dsp_model (
   input  wire logic        sys_clk_in,  // Clock
   input  wire logic        rst_in,      // Reset
   input  wire logic        dac_stb_in,  // D/A pulse
   input  wire logic        adc_stb_in,  // A/D pulse
   output logic      [31:0] dac_per_out, // Last D/A period
   output logic      [31:0] adc_per_out  // Last A/D period
);
   logic [31:0] dac_cnt, adc_cnt;  // Running counts
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         dac_cnt <= 32'h0;
         adc_cnt <= 32'h0;
         dac_per_out <= 32'h0;
         adc_per_out <= 32'h0;
      end else begin
         dac_cnt <= dac_stb_in ? 32'h1 : dac_cnt + 32'h1;
         adc_cnt <= adc_stb_in ? 32'h1 : adc_cnt + 32'h1;
         if (dac_stb_in) dac_per_out <= dac_cnt;
         if (adc_stb_in) adc_per_out <= adc_cnt;
      end
   end
endmodule // ctc_dsp_model

// file: bench/testbench.sv
// Purpose: Self-checking bench of the conversion timing control
// Assumes: Register port master, 100 MHz clock
// Notes:   Expectations queued, checked as results appear
`timescale 1ns/1ps
module testbench;
   import ctc_pkg::*;
   logic sys_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;  // Drives
   logic [7:0]  addr_in = 8'h00;     // Address
   logic [31:0] wr_data_in = 32'h0;  // Write data
   logic [31:0] rd_data_out, dac_per, adc_per;  // Results
   logic rx_fclk_out, tx_fclk_out, adc_stb_out, dac_stb_out, tx_ready_out;
   logic sync_mode_out, byte_mode_out, aux_sel_out, bypass_out;
   logic [1:0]  gain_out;
   logic [13:0] dac_data_out;
   logic [31:0] rq[$], pdq[$], paq[$], dq[$], mq[$];  // Expected notes
   logic rd_q = 1'b0, ds_q = 1'b0, as_q = 1'b0;        // Result flags
   logic [15:0] lfsr = 16'h0059;                       // Seed 89
   logic [7:0]  ta[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
   logic [31:0] te[8] = '{32'h0, 32'(CTC_DIVA_RST), 32'(CTC_DIVB_RST), 32'(CTC_DIVA_RST),
                          32'(CTC_DIVB_RST), 32'h0, 32'h1, 32'h0};
   logic [5:0]  tm[4] = '{6'h04, 6'h12, 6'h0B, 6'h2D};  // Four port modes
   int fail_count = 0, samples_checked = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   ctc_conv_timing uut (.sys_clk_in, .rst_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
      .rd_data_out, .rx_fclk_out, .tx_fclk_out, .adc_stb_out, .dac_stb_out, .dac_data_out,
      .sync_mode_out, .byte_mode_out, .gain_out, .aux_sel_out, .bypass_out, .tx_ready_out);
   ctc_dsp_model dsp (.sys_clk_in, .rst_in, .dac_stb_in(dac_stb_out),
      .adc_stb_in(adc_stb_out), .dac_per_out(dac_per), .adc_per_out(adc_per));
   // ****************************************
   // Tasks
   // ****************************************
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [5:0] fix(input logic [5:0] c);
      return (c[3:2] == 2'h3) ? {c[5:4], 2'h0, c[1:0]} : c;
   endfunction
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_rd(input logic [31:0] e, g); cmp("read", e, g); endtask
   task automatic chk_per(input logic [31:0] e, g); cmp("period", e, g); endtask
   task automatic chk_smp(input logic [31:0] e, g); cmp("sample", e, g); endtask
   task automatic chk_mode(input logic [31:0] e, g); cmp("mode", e, g); endtask
   task automatic chk_rdy(input logic [31:0] e, g); cmp("ready", e, g); endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
   endtask
   task automatic wstb;
      int i;
      for (i = 0; i < 20000; i++) begin
         @(posedge sys_clk_in);
         #1;
         if (dac_stb_out === 1'b1) break;
      end
      // Missing strobe counts as a mismatch
      if (i == 20000) fail_count++;
      @(posedge sys_clk_in);
   endtask
   task automatic per(input logic [31:0] d, a);
      repeat (3) wstb();
      pdq.push_back(d);
      paq.push_back(a);
   endtask
   task automatic wrap_up;
      $display("TB: checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Result watcher
   always @(posedge sys_clk_in) begin
      rd_q <= rd_in;
      ds_q <= dac_stb_out;
      as_q <= adc_stb_out;
      if (rd_q) chk_rd(rq.pop_front(), rd_data_out);
      if (ds_q && pdq.size() > 0) chk_per(pdq.pop_front(), dac_per);
      if (as_q && paq.size() > 0) chk_per(paq.pop_front(), adc_per);
      if (ds_q && dq.size() > 0) chk_smp(dq.pop_front(), 32'(dac_data_out));
      if (ds_q && mq.size() > 0) chk_mode(mq.pop_front(), 32'(uut.gain_out) << 2 |
         {26'h0, bypass_out, aux_sel_out, 2'h0, byte_mode_out, sync_mode_out});
   end
   // Watchdog
   initial begin
      #400000;
      fail_count++;
      wrap_up();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 8; i++) rd(ta[i], te[i]);
      $display("TB: test reset done");
      wr(CTC_OFS_TXA, 32'h2);
      wr(CTC_OFS_TXB, 32'h3);
      wr(CTC_OFS_RXA, 32'h1);
      wr(CTC_OFS_RXB, 32'h4);
      wr(8'h1C, 32'h7);
      rd(CTC_OFS_TXB, 32'h3);
      rd(8'h1C, 32'h0);
      per(32'd12, 32'd8);
      $display("TB: test dividers done");
      for (int i = 0; i < 4; i++) begin
         wstb();
         wr(CTC_OFS_CTRL, 32'(tm[i]));
         mq.push_back(32'(fix(tm[i])));
         rd(CTC_OFS_CTRL, 32'(fix(tm[i])));
         repeat (2) wstb();
      end
      per(32'd12, 32'd12);
      $display("TB: test modes done");
      wr(CTC_OFS_CTRL, 32'h0);
      wr(CTC_OFS_TXA, 32'h8);
      wr(CTC_OFS_TXB, 32'h4);
      per(32'd64, 32'd8);
      wstb();
      for (int i = 0; i < 16; i++) begin
         lfsr = lfsr_next(lfsr);
         wr(CTC_OFS_TXDATA, {18'h0, lfsr[13:0]});
         dq.push_back({18'h0, lfsr[13:0]});
      end
      wr(CTC_OFS_TXDATA, 32'h1555);
      rd(CTC_OFS_STATUS, 32'h1006);
      chk_rdy(32'h0, 32'(tx_ready_out));
      for (int i = 0; i < 20 && dq.size() > 0; i++) wstb();
      wstb();
      rd(CTC_OFS_STATUS, 32'h5);
      wr(CTC_OFS_STATUS, 32'h4);
      rd(CTC_OFS_STATUS, 32'h1);
      chk_rdy(32'h1, 32'(tx_ready_out));
      repeat (4) @(posedge sys_clk_in);
      cmp("pending", 32'h0, 32'(rq.size() + pdq.size() + paq.size() + dq.size() + mq.size()));
      $display("TB: test buffer done");
      wrap_up();
   end
endmodule // testbench
